// >>> hdl/reset_status_and_esr_filter.sv
// reset cause word, request pin filters and self-test done flag
`timescale 1ns/1ps
`default_nettype none
module reset_status_and_esr_filter
(
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // reset events, one-cycle pulses
  input wire logic cold_por_i,
  input wire logic warm_por_i,
  input wire logic low_voltage_detect_i,
  input wire logic system_reset_i,
  input wire logic app_reset_i,
  // supply monitor causes
  input wire logic supply_below_lvd_i,
  input wire logic supply_watchdog_monitor_flag_i,
  input wire logic regulator_3v3_monitor_flag_i,
  input wire logic core_regulator_monitor_flag_i,
  // request pins, active low
  input wire logic [reset_status_pkg::PIN_N-1:0] external_service_request_pin_n_i,
  input wire logic filter_enable_wr_i,
  input wire logic [reset_status_pkg::PIN_N-1:0] request_pin_filter_enable_i,
  // self-test
  input wire logic selftest_start_cfg_i,
  input wire logic selftest_pass_i,
  input wire logic test_clock_pin_i,
  input wire logic sram_init_done_i,
  // status
  output logic [reset_status_pkg::WORD_W-1:0] reset_cause_word_o,
  output logic [reset_status_pkg::PIN_N-1:0] request_pin_filter_enable_o,
  output logic [reset_status_pkg::PIN_N-1:0] request_trigger_o,
  output logic logic_selftest_done_o,
  output logic selftest_busy_o,
  output logic sram_init_required_o
);
  logic por_event;
  logic [reset_status_pkg::PIN_N-1:0] req_s1_reg;
  logic [reset_status_pkg::PIN_N-1:0] req_s2_reg;
  logic [reset_status_pkg::PIN_N-1:0] level;
  logic [reset_status_pkg::PIN_N-1:0] level_d_reg;
  logic [reset_status_pkg::MON_N-1:0] mon_causes;
  reset_status_pkg::selftest_state_type state_reg;
  logic [reset_status_pkg::RUN_CNT_W-1:0] run_cnt_reg;
  logic run_last;

  // a low-voltage-detect reset is a power-on reset as well
  assign por_event = cold_por_i | warm_por_i | low_voltage_detect_i;
  assign mon_causes = {core_regulator_monitor_flag_i, regulator_3v3_monitor_flag_i,
                       supply_watchdog_monitor_flag_i};
  assign run_last = run_cnt_reg == reset_status_pkg::RUN_CNT_W'(reset_status_pkg::RUN_CYC - 1);

  // cause word; lvd outranks a simultaneous cold power-on
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      reset_cause_word_o <= reset_status_pkg::CAUSE_RESET;
    end
    else if (clk_en_i)
    begin
      if (low_voltage_detect_i)
      begin
        reset_cause_word_o <= reset_status_pkg::POR_MASK |
          (supply_below_lvd_i ? reset_status_pkg::STBY_MASK : reset_status_pkg::CAUSE_RESET);
      end
      else if (cold_por_i)
      begin
        reset_cause_word_o <= reset_status_pkg::POR_MASK |
          (reset_status_pkg::WORD_W'(mon_causes) << reset_status_pkg::MON_LSB);
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      request_pin_filter_enable_o <= reset_status_pkg::FILTER_EN_RESET;
    end
    else if (clk_en_i && filter_enable_wr_i)
    begin
      request_pin_filter_enable_o <= request_pin_filter_enable_i;
    end
  end

  // pins are synchronous by contract, two stages kept against metastability anyway
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      req_s1_reg <= '0;
      req_s2_reg <= '0;
    end
    else if (clk_en_i)
    begin
      req_s1_reg <= ~external_service_request_pin_n_i;
      req_s2_reg <= req_s1_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < reset_status_pkg::PIN_N; gi++)
    begin : g_pin
      request_pin_filter u_filter
      (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .filter_en_i(request_pin_filter_enable_o[gi]),
        .request_i(req_s2_reg[gi]),
        .level_o(level[gi])
      );

      property p_reject;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(level[gi]) && $past(request_pin_filter_enable_o[gi]) |->
          $past(req_s2_reg[gi], 2) && $past(req_s2_reg[gi], 3) && $past(req_s2_reg[gi], 4) &&
          $past(req_s2_reg[gi], 5);
      endproperty
      a_reject: assert property (p_reject) else $error("short request passed filter");

      sequence s_held;
        (clk_en_i && request_pin_filter_enable_o[gi] && req_s2_reg[gi]) [*6];
      endsequence
      property p_accept;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        s_held |-> level[gi];
      endproperty
      a_accept: assert property (p_accept) else $error("long request not accepted");

      property p_bypass;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        clk_en_i && !request_pin_filter_enable_o[gi] |=> level[gi] == $past(req_s2_reg[gi]);
      endproperty
      a_bypass: assert property (p_bypass) else $error("bypass level wrong");
    end
  endgenerate

  // edge detect gives one trigger per accepted request
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      level_d_reg <= '0;
      request_trigger_o <= '0;
    end
    else if (clk_en_i)
    begin
      level_d_reg <= level;
      request_trigger_o <= level & ~level_d_reg;
    end
  end

  // self-test sequencer; system and application resets deliberately not inputs here
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= reset_status_pkg::ST_IDLE;
      run_cnt_reg <= '0;
      selftest_busy_o <= 1'b0;
      logic_selftest_done_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (por_event)
      begin
        logic_selftest_done_o <= 1'b0;
        run_cnt_reg <= '0;
        state_reg <= selftest_start_cfg_i ? reset_status_pkg::ST_RUN : reset_status_pkg::ST_IDLE;
        selftest_busy_o <= selftest_start_cfg_i;
      end
      else
      begin
        unique case (state_reg)
          reset_status_pkg::ST_IDLE:
          begin
            run_cnt_reg <= '0;
          end
          reset_status_pkg::ST_RUN:
          begin
            if (!test_clock_pin_i)
            begin
              if (run_last)
              begin
                state_reg <= reset_status_pkg::ST_IDLE;
                selftest_busy_o <= 1'b0;
                logic_selftest_done_o <= selftest_pass_i;
              end
              else
              begin
                run_cnt_reg <= run_cnt_reg + 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // scan chain disturbs memory redundancy, so memory is flagged untrusted after each run that reaches its last cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sram_init_required_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (state_reg == reset_status_pkg::ST_RUN && !test_clock_pin_i && run_last)
      begin
        sram_init_required_o <= 1'b1;
      end
      else if (sram_init_done_i)
      begin
        sram_init_required_o <= 1'b0;
      end
    end
  end

  property p_cold_word;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && cold_por_i && !low_voltage_detect_i |=>
      reset_cause_word_o[reset_status_pkg::POR_BIT] && !reset_cause_word_o[reset_status_pkg::STBY_BIT] &&
      reset_cause_word_o[reset_status_pkg::MON_LSB +: reset_status_pkg::MON_N] == $past(mon_causes);
  endproperty
  a_cold_word: assert property (p_cold_word) else $error("cold cause word wrong");

  property p_lvd_word;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && low_voltage_detect_i && supply_below_lvd_i |=>
      reset_cause_word_o == (reset_status_pkg::POR_MASK | reset_status_pkg::STBY_MASK);
  endproperty
  a_lvd_word: assert property (p_lvd_word) else $error("lvd cause word wrong");

  property p_stby_cause;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(reset_cause_word_o[reset_status_pkg::STBY_BIT]) |->
      $past(low_voltage_detect_i && supply_below_lvd_i && clk_en_i);
  endproperty
  a_stby_cause: assert property (p_stby_cause) else $error("standby flag without lvd");

  property p_lvd_mon;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && low_voltage_detect_i |=> (reset_cause_word_o & reset_status_pkg::MON_MASK) == '0;
  endproperty
  a_lvd_mon: assert property (p_lvd_mon) else $error("monitor flag after lvd");

  property p_done_keep;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    (system_reset_i || app_reset_i) && !por_event && state_reg == reset_status_pkg::ST_IDLE |=>
      $stable(logic_selftest_done_o);
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("done lost on warm reset");

  sequence s_por_run;
    clk_en_i && por_event && selftest_start_cfg_i;
  endsequence
  property p_done_clear;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_por_run |=> !logic_selftest_done_o && selftest_busy_o;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done not cleared on por");

  property p_stall;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    test_clock_pin_i && !por_event && state_reg == reset_status_pkg::ST_RUN |=>
      $stable(run_cnt_reg) && selftest_busy_o;
  endproperty
  a_stall: assert property (p_stall) else $error("self-test ran with test clock high");

  property p_sram;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    // busy also drops when the block reset clears it, which is not a finished run
    $fell(selftest_busy_o) && !$past(por_event) && !$past(sys_rst_i) |-> sram_init_required_o;
  endproperty
  a_sram: assert property (p_sram) else $error("memory not flagged after self-test");
endmodule
`default_nettype wire

// >>> pkg/reset_status_pkg.sv
// constants for the reset status and request pin filter block
// Overview of operation
// - cold power-on loads cause word 0X01_0000: power-on flag plus causing monitor flag
// - low-voltage-detect reset loads cause word 1001_0000 or 0001_0000: power-on flag, plus standby flag when below the limit
// - standby flag set only when supply fell below the low-voltage-detect limit
// - after low-voltage-detect reset the three supply monitor flags stay cleared
// - per-pin filter, enabled after reset, rejects pulses shorter than 30 ns
// - filtered pulses longer than 100 ns always trigger at 50 MHz or faster
// - self-test done flag survives system and application resets
// - warm or cold power-on clears done flag; configured self-test then updates it
// - self-test corrupts memory redundancy; memory must be initialised before use
// - self-test stalls while the test clock pin is held high
package reset_status_pkg;
  localparam int WORD_W = 32;
  localparam int PIN_N = 2;
  localparam int POR_BIT = 16;
  localparam int STBY_BIT = 28;
  localparam int MON_LSB = 24;
  localparam int MON_N = 3;
  localparam logic [WORD_W-1:0] POR_MASK = 32'h0001_0000;
  localparam logic [WORD_W-1:0] STBY_MASK = 32'h1000_0000;
  localparam logic [WORD_W-1:0] MON_MASK = 32'h0700_0000;
  localparam logic [WORD_W-1:0] CAUSE_RESET = 32'h0000_0000;
  localparam logic [PIN_N-1:0] FILTER_EN_RESET = 2'h3;
  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int GLITCH_NS = 30;
  localparam int REJECT_CYC = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCEPT_CYC = REJECT_CYC + 1;
  localparam int FILT_CNT_W = 3;
  localparam int RUN_CYC = 16;
  localparam int RUN_CNT_W = 5;
  typedef enum logic {ST_IDLE, ST_RUN} selftest_state_type;
endpackage

// >>> hdl/request_pin_filter.sv
// glitch filter for one synchronised service request input
`timescale 1ns/1ps
`default_nettype none
module request_pin_filter
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // control and data
  input wire logic filter_en_i,
  input wire logic request_i,
  output logic level_o
);
  logic [reset_status_pkg::FILT_CNT_W-1:0] cnt_reg;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      level_o <= 1'b0;
      cnt_reg <= '0;
    end
    else if (clk_en_i)
    begin
      if (!filter_en_i || request_i == level_o)
      begin
        level_o <= request_i;
        cnt_reg <= '0;
      end
      else if (cnt_reg == reset_status_pkg::FILT_CNT_W'(reset_status_pkg::ACCEPT_CYC - 1))
      begin
        // level changes only after ACCEPT_CYC equal samples
        level_o <= request_i;
        cnt_reg <= '0;
      end
      else
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/board_pins_model.sv
// board side model: request pins and test clock pin
`timescale 1ns/1ps
`default_nettype none
module board_pins_model
(
  // clock
  input wire logic sys_clk_i,
  // board pins
  output var logic [reset_status_pkg::PIN_N-1:0] request_pin_n_o,
  output var logic test_clock_pin_o
);
  // idle request pins pulled up, test clock pin pulled down
  initial
  begin
    request_pin_n_o = 2'h3;
    test_clock_pin_o = 1'b0;
  end
  // low pulse lasting len clock cycles on one pin
  task automatic pulse(input int pin, input int len);
    request_pin_n_o[pin] = 1'b0;
    repeat (len) @(posedge sys_clk_i);
    #1;
    request_pin_n_o[pin] = 1'b1;
  endtask
  task automatic set_tck(input logic v);
    test_clock_pin_o = v;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for reset cause word, request filters and self-test flag
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk_i, sys_rst_i, clk_en_i, cold_por_i, warm_por_i, low_voltage_detect_i;
  logic system_reset_i, app_reset_i, supply_below_lvd_i, filter_enable_wr_i, test_clock_pin_i;
  logic selftest_start_cfg_i, selftest_pass_i, sram_init_done_i;
  logic logic_selftest_done_o, selftest_busy_o, sram_init_required_o;
  logic [2:0] mons;
  logic [reset_status_pkg::PIN_N-1:0] pins_n, request_pin_filter_enable_i, request_pin_filter_enable_o;
  logic [reset_status_pkg::PIN_N-1:0] request_trigger_o;
  logic [reset_status_pkg::WORD_W-1:0] reset_cause_word_o;
  int miscompares = 0;
  int n_tests = 0;
  integer seed = 83;
  int cycles = 0;
  int trig_cnt [2] = '{0, 0};

  reset_status_and_esr_filter uut
  (
    .sys_clk_i, .sys_rst_i, .clk_en_i, .cold_por_i, .warm_por_i, .low_voltage_detect_i,
    .system_reset_i, .app_reset_i, .supply_below_lvd_i,
    .supply_watchdog_monitor_flag_i(mons[0]),
    .regulator_3v3_monitor_flag_i(mons[1]),
    .core_regulator_monitor_flag_i(mons[2]),
    .external_service_request_pin_n_i(pins_n),
    .filter_enable_wr_i, .request_pin_filter_enable_i,
    .selftest_start_cfg_i, .selftest_pass_i, .test_clock_pin_i, .sram_init_done_i,
    .reset_cause_word_o, .request_pin_filter_enable_o, .request_trigger_o,
    .logic_selftest_done_o, .selftest_busy_o, .sram_init_required_o
  );

  board_pins_model board
  (
    .sys_clk_i,
    .request_pin_n_o(pins_n),
    .test_clock_pin_o(test_clock_pin_i)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // sampled on the falling edge so each one-cycle trigger counts once
  always @(negedge sys_clk_i)
  begin
    cycles++;
    for (int k = 0; k < 2; k++)
      if (request_trigger_o[k] === 1'b1)
        trig_cnt[k]++;
    if (cycles == 3000)
    begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    if (got !== exp)
      miscompares++;
  endtask

  function automatic logic [31:0] exp_word(input logic low_voltage_detect, input logic below, input logic [2:0] m);
    if (low_voltage_detect)
      return reset_status_pkg::POR_MASK | (below ? reset_status_pkg::STBY_MASK : 32'h0000_0000);
    return reset_status_pkg::POR_MASK | {5'h00, m, 24'h00_0000};
  endfunction

  // one-cycle event pulse; answer is settled two edges later
  task automatic event_pulse(input logic cold, input logic warm, input logic low_voltage_detect, input logic cfg);
    cold_por_i = cold;
    warm_por_i = warm;
    low_voltage_detect_i = low_voltage_detect;
    selftest_start_cfg_i = cfg;
    step(1);
    cold_por_i = 1'b0;
    warm_por_i = 1'b0;
    low_voltage_detect_i = 1'b0;
    step(1);
  endtask

  task automatic wait_idle;
    int i;
    i = 0;
    while (selftest_busy_o !== 1'b0 && i < 60)
    begin
      step(1);
      i++;
    end
    step(1);
    chk(selftest_busy_o, 1'b0, "self-test end");
  endtask

  task automatic req_pulse(input int pin, input int len, input int exp_n);
    int base;
    base = trig_cnt[pin];
    board.pulse(pin, len);
    step(30);
    chk(trig_cnt[pin] - base, exp_n, "trigger count");
  endtask

  task automatic set_filt(input logic [1:0] v);
    filter_enable_wr_i = 1'b1;
    request_pin_filter_enable_i = v;
    step(1);
    filter_enable_wr_i = 1'b0;
    step(1);
    chk(request_pin_filter_enable_o, v, "filter enable");
  endtask

  initial
  begin
    {cold_por_i, warm_por_i, low_voltage_detect_i, system_reset_i, app_reset_i} = 5'h00;
    {supply_below_lvd_i, filter_enable_wr_i, selftest_start_cfg_i, selftest_pass_i} = 4'h0;
    sram_init_done_i = 1'b0;
    mons = 3'h0;
    request_pin_filter_enable_i = 2'h3;
    clk_en_i = 1'b1;
    sys_rst_i = 1'b1;
    step(10);
    sys_rst_i = 1'b0;
    step(1);
    chk(reset_cause_word_o, reset_status_pkg::CAUSE_RESET, "reset word");
    chk({request_pin_filter_enable_o, logic_selftest_done_o, selftest_busy_o, sram_init_required_o}, 32'h0000_0018,
        "reset flags");
    $display("test reset values done");
    for (int m = 0; m < 8; m++)
    begin
      mons = m[2:0];
      supply_below_lvd_i = 1'($random(seed));
      selftest_pass_i = 1'($random(seed));
      event_pulse(1'b1, 1'b0, 1'b0, 1'b1);
      chk(reset_cause_word_o, exp_word(1'b0, 1'b0, m[2:0]), "cold word");
      wait_idle();
      chk(logic_selftest_done_o, selftest_pass_i, "done result");
      chk(sram_init_required_o, 1'b1, "memory init needed");
      sram_init_done_i = 1'b1;
      step(1);
      sram_init_done_i = 1'b0;
      step(1);
      chk(sram_init_required_o, 1'b0, "memory init cleared");
    end
    // frozen clock enable must ignore the event
    clk_en_i = 1'b0;
    event_pulse(1'b0, 1'b0, 1'b1, 1'b0);
    clk_en_i = 1'b1;
    chk(reset_cause_word_o, exp_word(1'b0, 1'b0, 3'h7), "event while frozen");
    $display("test cold power-on done");
    for (int c = 0; c < 3; c++)
    begin
      mons = 3'($random(seed)) | 3'h1;
      supply_below_lvd_i = (c != 0);
      event_pulse(c == 2, 1'b0, 1'b1, 1'b0);
      chk(reset_cause_word_o, exp_word(1'b1, c != 0, 3'h0), "lvd word");
    end
    $display("test low-voltage reset done");
    board.set_tck(1'b1);
    selftest_pass_i = 1'b1;
    event_pulse(1'b1, 1'b0, 1'b0, 1'b1);
    step(30);
    chk(selftest_busy_o, 1'b1, "stalled run");
    board.set_tck(1'b0);
    wait_idle();
    chk(logic_selftest_done_o, 1'b1, "run after stall");
    system_reset_i = 1'b1;
    app_reset_i = 1'b1;
    step(1);
    system_reset_i = 1'b0;
    app_reset_i = 1'b0;
    step(2);
    chk(logic_selftest_done_o, 1'b1, "done kept");
    event_pulse(1'b0, 1'b1, 1'b0, 1'b0);
    chk(logic_selftest_done_o, 1'b0, "done cleared by warm power-on");
    // lvd starting a run, restart by warm power-on, exact run length
    supply_below_lvd_i = 1'b1;
    event_pulse(1'b0, 1'b0, 1'b1, 1'b1);
    chk(reset_cause_word_o, exp_word(1'b1, 1'b1, 3'h0), "lvd word with run");
    step(5);
    event_pulse(1'b0, 1'b1, 1'b0, 1'b1);
    chk({logic_selftest_done_o, selftest_busy_o}, 2'h1, "run restarted");
    step(reset_status_pkg::RUN_CYC - 2);
    chk(selftest_busy_o, 1'b1, "run length");
    step(1);
    chk({logic_selftest_done_o, selftest_busy_o}, 2'h2, "run result");
    // block reset in mid-run restores every reset value
    event_pulse(1'b1, 1'b0, 1'b0, 1'b1);
    step(3);
    sys_rst_i = 1'b1;
    step(1);
    sys_rst_i = 1'b0;
    step(2);
    chk(reset_cause_word_o, reset_status_pkg::CAUSE_RESET, "mid-run reset word");
    chk({request_pin_filter_enable_o, logic_selftest_done_o, selftest_busy_o, sram_init_required_o}, 32'h0000_0018,
        "mid-run reset flags");
    $display("test self-test done");
    // short pulses stay at or below 24 ns, long ones above 100 ns
    for (int i = 0; i < 6; i++)
    begin
      req_pulse(i % 2, 1 + ($unsigned($random(seed)) % 3), 0);
      req_pulse(i % 2, 13 + ($unsigned($random(seed)) % 8), 1);
    end
    set_filt(2'h2);
    req_pulse(0, 1, 1);
    req_pulse(1, 2, 0);
    set_filt(2'h0);
    req_pulse(1, 1, 1);
    set_filt(2'h3);
    $display("test request filter done");
    give_verdict();
  end
endmodule
`default_nettype wire
